// file: hw/gpio_port_regs.svh
// register offsets, reset values and bit masks of the gpio port block
`ifndef GPIO_PORT_REGS_SVH
`define GPIO_PORT_REGS_SVH

// special-function register offsets
`define PORT_A_DATA_OFS       8'hF8
`define PORT_B_DATA_OFS       8'h80
`define PORT_C_DATA_OFS       8'h90
`define PORT_D_DATA_OFS       8'h98
`define LED_SCAN_CONTROL_OFS  8'hB0
`define PORT_B_PULLDOWN_OFS   8'hD8
`define PORT_A_PULLUP_OFS     8'hDD
`define PORT_B_PULLUP_OFS     8'hDE
`define PORT_C_PULLUP_OFS     8'hDF
`define PORT_D_PULLUP_OFS     8'hE2
`define PORT_A_DIRECTION_OFS  8'hEA
`define PORT_B_DIRECTION_OFS  8'hEB
`define PORT_C_DIRECTION_OFS  8'hEC
`define PORT_D_DIRECTION_OFS  8'hED

// secondary bus offsets
`define COM_PIN_SELECT_OFS    8'h2B
`define OPEN_DRAIN_ENABLE_OFS 8'h2C

// reset values
`define PORT_A_DATA_RST       8'h3F
`define PORT_BCD_DATA_RST     8'hFF
`define PORT_A_DIRECTION_RST  8'h3F
`define PORT_BCD_DIR_RST      8'hFF
`define CTRL_RST              8'h00

// implemented bits
`define PORT_A_MASK           8'h3F
`define OPEN_DRAIN_MASK       8'h07
`define LED_SCAN_MASK         8'h1F

// field positions
`define SINK_LOCK_BIT         0
`define OD_PA0_BIT            0
`define OD_PA1_BIT            1
`define OD_PD6_BIT            2
`define PD6_PIN               6

`endif

// file: hw/gpio_port_pkg.sv
// types shared by the gpio port block
`default_nettype none

package gpio_port_pkg;

  // drive of one 8-pin group towards the pads
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } pad_s;

  // configuration of one 8-pin group
  typedef struct packed {
    logic [7:0] pinDirectionBits;
    logic [7:0] pinOutputBits;
    logic [7:0] opendrainSelect;
  } port_cfg_s;

  // alternate function that may take a pin over
  typedef struct packed {
    logic [7:0] enable;
    logic [7:0] out;
    logic [7:0] oe;
  } alt_drive_s;

endpackage : gpio_port_pkg

`default_nettype wire

// file: hw/pin_sync.sv
// two-flop synchroniser for a group of pad inputs
`default_nettype none

module pin_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1_q;
  logic [WIDTH-1:0] stage1_d;
  logic [WIDTH-1:0] stage2_q;
  logic [WIDTH-1:0] stage2_d;

  always_comb begin
    stage1_d = asyncIn;
    stage2_d = stage1_q;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      stage1_q <= '0;
      stage2_q <= '0;
    end else begin
      stage1_q <= stage1_d;
      stage2_q <= stage2_d;
    end
  end

  assign syncOut = stage2_q;

endmodule : pin_sync

`default_nettype wire

// file: hw/gpio_pin_bank.sv
// pad drive and readback for one group of eight pins
`default_nettype none

module gpio_pin_bank
  import gpio_port_pkg::*;
(
  input  wire logic                      clock,
  input  wire logic                      reset,
  input  wire gpio_port_pkg::port_cfg_s  cfg,
  input  wire gpio_port_pkg::alt_drive_s alt,
  input  wire logic [7:0]                implMask,
  input  wire logic [7:0]                padIn,
  output gpio_port_pkg::pad_s            pad,
  output logic      [7:0]                readback
);

  logic [7:0] pinLevel;
  pad_s       pad_q;
  pad_s       pad_d;

  // pad levels come from another domain and are synchronised first
  pin_sync #(
    .WIDTH   (8)
  ) u_sync (
    .clock   (clock),
    .reset   (reset),
    .asyncIn (padIn),
    .syncOut (pinLevel)
  );

  always_comb begin
    pad_d = '0;
    for (int i = 0; i < 8; i++) begin
      if (alt.enable[i]) begin
        pad_d.out[i] = alt.out[i];
        pad_d.oe[i]  = alt.oe[i];
      end else if (cfg.opendrainSelect[i]) begin
        // open drain: only a low is driven, a high releases the pad
        pad_d.out[i] = 1'b0;
        pad_d.oe[i]  = ~cfg.pinDirectionBits[i]
                       & ~cfg.pinOutputBits[i];
      end else begin
        pad_d.out[i] = cfg.pinOutputBits[i];             // [RULE_02]
        pad_d.oe[i]  = ~cfg.pinDirectionBits[i];         // [RULE_01]
      end
    end
    pad_d.out = pad_d.out & implMask;
    pad_d.oe  = pad_d.oe & implMask;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      pad_q <= '0;
    end else begin
      pad_q <= pad_d;
    end
  end

  assign pad = pad_q;

  // inputs show the pad, outputs the last written value
  assign readback = implMask & ((cfg.pinDirectionBits & pinLevel)
                    | (~cfg.pinDirectionBits & cfg.pinOutputBits)); // [RULE_03]

endmodule : gpio_pin_bank

`default_nettype wire

// file: hw/gpio_port_config.sv
// gpio port configuration block: registers, pin control, sink lock
//
// Operation
// RULE_01 - A direction bit of 1 makes its pin an input and 0 an output.
// RULE_02 - An output pin is driven to the level of its data bit.
// RULE_03 - Data reads return the pad level for inputs, else written data.
// RULE_04 - A pull-up bit of 1 switches on that pin's internal pull-up.
// RULE_05 - A port B pull-down bit of 1 switches on that pin's pull-down.
// RULE_06 - Open-drain bits 0, 1, 2 select open drain on PA0, PA1, PD6.
// RULE_07 - An enabled IIC function forces open drain on its pins.
// RULE_08 - The sink lock bit at 1 locks the COM pins as sink I/O.
// RULE_09 - While locked, COM pins follow GPIO registers, not LED scan.
// RULE_10 - Each COM select bit puts the same port B pin into COM mode.
// RULE_11 - Port A has only six pins; ports B, C and D have eight.
// RULE_12 - Software must not give one pin two peripheral functions.
// RULE_13 - COM select and open-drain sit on the secondary bus only.
// RULE_14 - Port B provides high-current sink drive on its eight pins.
// RULE_15 - IIC and UART lines should use external pull-up resistors.
// RULE_16 - Unimplemented register bits read as zero and ignore writes.
`include "gpio_port_regs.svh"
`default_nettype none

module gpio_port_config (
  input  wire logic                 clock,
  input  wire logic                 reset,
  // special-function register bus
  input  wire logic [7:0]           sfrAddr,
  input  wire logic                 sfrWrite,
  input  wire logic                 sfrRead,
  input  wire logic [7:0]           sfrWdata,
  output logic      [7:0]           sfrRdata,
  // secondary register bus
  input  wire logic [7:0]           secAddr,
  input  wire logic                 secWrite,
  input  wire logic                 secRead,
  input  wire logic [7:0]           secWdata,
  output logic      [7:0]           secRdata,
  // peripheral side
  input  wire logic                 iicEnable,
  input  wire logic [7:0]           ledComOut,
  input  wire logic [7:0]           ledComOe,
  // pads
  input  wire logic [7:0]           paIn,
  input  wire logic [7:0]           pbIn,
  input  wire logic [7:0]           pcIn,
  input  wire logic [7:0]           pdIn,
  output gpio_port_pkg::pad_s       paPad,
  output gpio_port_pkg::pad_s       pbPad,
  output gpio_port_pkg::pad_s       pcPad,
  output gpio_port_pkg::pad_s       pdPad,
  output logic      [7:0]           paPullup,
  output logic      [7:0]           pbPullup,
  output logic      [7:0]           pcPullup,
  output logic      [7:0]           pdPullup,
  output logic      [7:0]           pbPulldown,
  output logic      [7:0]           pbHighSink,
  output logic                      sinkPortLock
);

  import gpio_port_pkg::*;

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [7:0] paDir_q, paDir_d;
  logic [7:0] pbDir_q, pbDir_d;
  logic [7:0] pcDir_q, pcDir_d;
  logic [7:0] pdDir_q, pdDir_d;
  logic [7:0] paData_q, paData_d;
  logic [7:0] pbData_q, pbData_d;
  logic [7:0] pcData_q, pcData_d;
  logic [7:0] pdData_q, pdData_d;
  logic [7:0] paPu_q, paPu_d;
  logic [7:0] pbPu_q, pbPu_d;
  logic [7:0] pcPu_q, pcPu_d;
  logic [7:0] pdPu_q, pdPu_d;
  logic [7:0] pbPd_q, pbPd_d;
  logic [7:0] ledScanCtrl_q, ledScanCtrl_d;
  logic [7:0] commonLineSelect_q, commonLineSelect_d;
  logic [7:0] opendrain_q, opendrain_d;
  logic [7:0] highSink_q, highSink_d;
  logic [7:0] sfrRdata_q, sfrRdata_d;
  logic [7:0] secRdata_q, secRdata_d;

  logic [7:0] paRead, pbRead, pcRead, pdRead;
  logic       lockBit;

  assign lockBit = ledScanCtrl_q[`SINK_LOCK_BIT];

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  always_comb begin
    paDir_d            = paDir_q;
    pbDir_d            = pbDir_q;
    pcDir_d            = pcDir_q;
    pdDir_d            = pdDir_q;
    paData_d           = paData_q;
    pbData_d           = pbData_q;
    pcData_d           = pcData_q;
    pdData_d           = pdData_q;
    paPu_d             = paPu_q;
    pbPu_d             = pbPu_q;
    pcPu_d             = pcPu_q;
    pdPu_d             = pdPu_q;
    pbPd_d             = pbPd_q;
    ledScanCtrl_d      = ledScanCtrl_q;
    commonLineSelect_d = commonLineSelect_q;
    opendrain_d        = opendrain_q;
    if (sfrWrite) begin
      unique case (sfrAddr)
        `PORT_A_DIRECTION_OFS: paDir_d  = sfrWdata & `PORT_A_MASK; // [RULE_11]
        `PORT_B_DIRECTION_OFS: pbDir_d  = sfrWdata;
        `PORT_C_DIRECTION_OFS: pcDir_d  = sfrWdata;
        `PORT_D_DIRECTION_OFS: pdDir_d  = sfrWdata;
        `PORT_A_DATA_OFS:      paData_d = sfrWdata & `PORT_A_MASK; // [RULE_16]
        `PORT_B_DATA_OFS:      pbData_d = sfrWdata;
        `PORT_C_DATA_OFS:      pcData_d = sfrWdata;
        `PORT_D_DATA_OFS:      pdData_d = sfrWdata;
        `PORT_A_PULLUP_OFS:    paPu_d   = sfrWdata & `PORT_A_MASK; // [RULE_11]
        `PORT_B_PULLUP_OFS:    pbPu_d   = sfrWdata;
        `PORT_C_PULLUP_OFS:    pcPu_d   = sfrWdata;
        `PORT_D_PULLUP_OFS:    pdPu_d   = sfrWdata;
        `PORT_B_PULLDOWN_OFS:  pbPd_d   = sfrWdata;
        `LED_SCAN_CONTROL_OFS: begin
          ledScanCtrl_d = sfrWdata & `LED_SCAN_MASK;               // [RULE_16]
        end
        default: ;
      endcase
    end
    // these two answer on the secondary bus and nowhere else
    if (secWrite) begin
      unique case (secAddr)
        `COM_PIN_SELECT_OFS:    commonLineSelect_d = secWdata;     // [RULE_13]
        `OPEN_DRAIN_ENABLE_OFS: begin
          opendrain_d = secWdata & `OPEN_DRAIN_MASK;               // [RULE_16]
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      paDir_q            <= `PORT_A_DIRECTION_RST;
      pbDir_q            <= `PORT_BCD_DIR_RST;
      pcDir_q            <= `PORT_BCD_DIR_RST;
      pdDir_q            <= `PORT_BCD_DIR_RST;
      paData_q           <= `PORT_A_DATA_RST;
      pbData_q           <= `PORT_BCD_DATA_RST;
      pcData_q           <= `PORT_BCD_DATA_RST;
      pdData_q           <= `PORT_BCD_DATA_RST;
      paPu_q             <= `CTRL_RST;
      pbPu_q             <= `CTRL_RST;
      pcPu_q             <= `CTRL_RST;
      pdPu_q             <= `CTRL_RST;
      pbPd_q             <= `CTRL_RST;
      ledScanCtrl_q      <= `CTRL_RST;
      commonLineSelect_q <= `CTRL_RST;
      opendrain_q        <= `CTRL_RST;
    end else begin
      paDir_q            <= paDir_d;
      pbDir_q            <= pbDir_d;
      pcDir_q            <= pcDir_d;
      pdDir_q            <= pdDir_d;
      paData_q           <= paData_d;
      pbData_q           <= pbData_d;
      pcData_q           <= pcData_d;
      pdData_q           <= pdData_d;
      paPu_q             <= paPu_d;
      pbPu_q             <= pbPu_d;
      pcPu_q             <= pcPu_d;
      pdPu_q             <= pdPu_d;
      pbPd_q             <= pbPd_d;
      ledScanCtrl_q      <= ledScanCtrl_d;
      commonLineSelect_q <= commonLineSelect_d;
      opendrain_q        <= opendrain_d;
    end
  end

  // ----------------------------------------------------------------
  // register reads
  // ----------------------------------------------------------------
  // read data is registered, so it is valid one cycle after the strobe;
  // it holds between reads so a slow core may sample it late
  always_comb begin
    sfrRdata_d = sfrRdata_q;
    secRdata_d = secRdata_q;
    if (sfrRead) begin
      unique case (sfrAddr)
        `PORT_A_DIRECTION_OFS: sfrRdata_d = paDir_q;
        `PORT_B_DIRECTION_OFS: sfrRdata_d = pbDir_q;
        `PORT_C_DIRECTION_OFS: sfrRdata_d = pcDir_q;
        `PORT_D_DIRECTION_OFS: sfrRdata_d = pdDir_q;
        `PORT_A_DATA_OFS:      sfrRdata_d = paRead;      // [RULE_03]
        `PORT_B_DATA_OFS:      sfrRdata_d = pbRead;      // [RULE_03]
        `PORT_C_DATA_OFS:      sfrRdata_d = pcRead;      // [RULE_03]
        `PORT_D_DATA_OFS:      sfrRdata_d = pdRead;      // [RULE_03]
        `PORT_A_PULLUP_OFS:    sfrRdata_d = paPu_q;
        `PORT_B_PULLUP_OFS:    sfrRdata_d = pbPu_q;
        `PORT_C_PULLUP_OFS:    sfrRdata_d = pcPu_q;
        `PORT_D_PULLUP_OFS:    sfrRdata_d = pdPu_q;
        `PORT_B_PULLDOWN_OFS:  sfrRdata_d = pbPd_q;
        `LED_SCAN_CONTROL_OFS: sfrRdata_d = ledScanCtrl_q;
        default:               sfrRdata_d = 8'h00;
      endcase
    end
    if (secRead) begin
      unique case (secAddr)
        `COM_PIN_SELECT_OFS:    secRdata_d = commonLineSelect_q; // [RULE_13]
        `OPEN_DRAIN_ENABLE_OFS: secRdata_d = opendrain_q;        // [RULE_16]
        default:                secRdata_d = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // sink lock and high-current drive
  // ----------------------------------------------------------------
  always_comb begin
    highSink_d = lockBit ? 8'hFF : 8'h00;                // [RULE_08] [RULE_14]
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      sfrRdata_q <= 8'h00;
      secRdata_q <= 8'h00;
      highSink_q <= 8'h00;
    end else begin
      sfrRdata_q <= sfrRdata_d;
      secRdata_q <= secRdata_d;
      highSink_q <= highSink_d;
    end
  end

  // ----------------------------------------------------------------
  // pin configuration per port
  // ----------------------------------------------------------------
  port_cfg_s  paCfg, pbCfg, pcCfg, pdCfg;
  alt_drive_s noAlt, pbAlt;

  assign noAlt = '0;

  always_comb begin
    paCfg = '{pinDirectionBits: paDir_q, pinOutputBits: paData_q,
              opendrainSelect: 8'h00};
    // the IIC pins are pulled to open drain whatever the select says
    paCfg.opendrainSelect[`OD_PA0_BIT] = opendrain_q[`OD_PA0_BIT]
                                         | iicEnable;    // [RULE_06] [RULE_07]
    paCfg.opendrainSelect[`OD_PA1_BIT] = opendrain_q[`OD_PA1_BIT]
                                         | iicEnable;    // [RULE_06] [RULE_07]
    pbCfg = '{pinDirectionBits: pbDir_q, pinOutputBits: pbData_q,
              opendrainSelect: 8'h00};
    pcCfg = '{pinDirectionBits: pcDir_q, pinOutputBits: pcData_q,
              opendrainSelect: 8'h00};
    pdCfg = '{pinDirectionBits: pdDir_q, pinOutputBits: pdData_q,
              opendrainSelect: 8'h00};
    pdCfg.opendrainSelect[`PD6_PIN] = opendrain_q[`OD_PD6_BIT]; // [RULE_06]
  end

  // a locked sink port ignores the scan engine entirely; the scan
  // engine owns a selected pin only while the lock is off
  always_comb begin
    pbAlt.enable = commonLineSelect_q & {8{~lockBit}};   // [RULE_09] [RULE_10]
    pbAlt.out    = ledComOut;
    pbAlt.oe     = ledComOe;
  end

  gpio_pin_bank u_port_a (
    .clock    (clock),
    .reset    (reset),
    .cfg      (paCfg),
    .alt      (noAlt),
    .implMask (`PORT_A_MASK),                            // [RULE_11]
    .padIn    (paIn),
    .pad      (paPad),
    .readback (paRead)
  );

  gpio_pin_bank u_port_b (
    .clock    (clock),
    .reset    (reset),
    .cfg      (pbCfg),
    .alt      (pbAlt),
    .implMask (8'hFF),
    .padIn    (pbIn),
    .pad      (pbPad),
    .readback (pbRead)
  );

  gpio_pin_bank u_port_c (
    .clock    (clock),
    .reset    (reset),
    .cfg      (pcCfg),
    .alt      (noAlt),
    .implMask (8'hFF),
    .padIn    (pcIn),
    .pad      (pcPad),
    .readback (pcRead)
  );

  gpio_pin_bank u_port_d (
    .clock    (clock),
    .reset    (reset),
    .cfg      (pdCfg),
    .alt      (noAlt),
    .implMask (8'hFF),
    .padIn    (pdIn),
    .pad      (pdPad),
    .readback (pdRead)
  );

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // pull resistors are analog switches fed straight from the registers
  assign paPullup     = paPu_q;                          // [RULE_04]
  assign pbPullup     = pbPu_q;                          // [RULE_04]
  assign pcPullup     = pcPu_q;                          // [RULE_04]
  assign pdPullup     = pdPu_q;                          // [RULE_04]
  assign pbPulldown   = pbPd_q;                          // [RULE_05]
  assign pbHighSink   = highSink_q;
  assign sinkPortLock = ledScanCtrl_q[`SINK_LOCK_BIT];   // [RULE_08]
  assign sfrRdata     = sfrRdata_q;
  assign secRdata     = secRdata_q;

endmodule : gpio_port_config

`default_nettype wire

// file: tb/gpio_port_config_chk.sv
// assertion checker for the gpio port configuration block
`default_nettype none

module gpio_port_config_chk (
  input wire logic                clock,
  input wire logic                reset,
  input wire logic [7:0]          sfrAddr,
  input wire logic                sfrWrite,
  input wire logic                sfrRead,
  input wire logic [7:0]          sfrWdata,
  input wire logic [7:0]          sfrRdata,
  input wire logic                secRead,
  input wire logic [7:0]          secRdata,
  input wire logic                iicEnable,
  input wire gpio_port_pkg::pad_s paPad,
  input wire logic [7:0]          paPullup,
  input wire logic [7:0]          pbPulldown,
  input wire logic [7:0]          pbHighSink,
  input wire logic                sinkPortLock
);
  import gpio_port_pkg::*;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);

  chk_sink_drive: assert property (
    pbHighSink == {8{$past(sinkPortLock)}})
    else $error("sink drive does not follow the lock bit");
  chk_lock_load: assert property (
    sfrWrite && sfrAddr == 8'hB0 |=> sinkPortLock == $past(sfrWdata[0]))
    else $error("lock bit not loaded by its write");
  chk_pa_upper: assert property (
    paPad.out[7:6] == 2'b00 && paPad.oe[7:6] == 2'b00)
    else $error("absent port A pins driven");
  chk_iic_drain: assert property (
    $past(iicEnable) && $past(iicEnable, 2) |-> paPad.out[1:0] == 2'b00)
    else $error("bus pins driven high while iic enabled");
  chk_rdata_hold: assert property (
    !sfrRead |=> $stable(sfrRdata))
    else $error("read data changed without a read");
  chk_sec_hold: assert property (
    !secRead |=> $stable(secRdata))
    else $error("secondary read data changed without a read");
  chk_unmapped_zero: assert property (
    sfrRead && sfrAddr == 8'h00 |=> sfrRdata == 8'h00)
    else $error("unmapped read not zero");
  chk_pulldown_load: assert property (
    sfrWrite && sfrAddr == 8'hD8 |=> pbPulldown == $past(sfrWdata))
    else $error("pull-down enables not loaded");
  chk_pullup_mask: assert property (
    sfrWrite && sfrAddr == 8'hDD |=>
      paPullup == ($past(sfrWdata) & 8'h3F))
    else $error("port A pull-ups not loaded or not masked");

  cover property (sfrWrite && sfrAddr == 8'hB0 && sfrWdata[0]);
  cover property (pbHighSink == 8'hFF);
  cover property ($past(iicEnable) && iicEnable);
endmodule : gpio_port_config_chk

`default_nettype wire

// file: tb/tb_gpio_port_config.sv
// self-checking testbench of the gpio port configuration block
`default_nettype none

module tb_gpio_port_config;
  timeunit 1ns;
  timeprecision 1ns;
  import gpio_port_pkg::*;

  logic       clock, reset, sfrWrite, sfrRead, secWrite, secRead, iicEnable;
  logic [7:0] sfrAddr, sfrWdata, sfrRdata, secAddr, secWdata, secRdata;
  logic [7:0] ledComOut, ledComOe, paIn, pbIn, pcIn, pdIn, got;
  logic [7:0] paPullup, pbPullup, pcPullup, pdPullup, pbPulldown, pbHighSink;
  logic       sinkPortLock;
  pad_s       paPad, pbPad, pcPad, pdPad;
  int         badCount, compares, cycles;

  // offsets, reset values and implemented bits of the special registers
  localparam logic [7:0] OFFS [14] = '{8'hF8, 8'h80, 8'h90, 8'h98, 8'hB0,
    8'hD8, 8'hDD, 8'hDE, 8'hDF, 8'hE2, 8'hEA, 8'hEB, 8'hEC, 8'hED};
  localparam logic [7:0] RSTS [14] = '{8'h3F, 8'hFF, 8'hFF, 8'hFF, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h3F, 8'hFF, 8'hFF, 8'hFF};
  localparam logic [7:0] MASKS [14] = '{8'h3F, 8'hFF, 8'hFF, 8'hFF, 8'h1F,
    8'hFF, 8'h3F, 8'hFF, 8'hFF, 8'hFF, 8'h3F, 8'hFF, 8'hFF, 8'hFF};

  gpio_port_config i_gpio_port_config (.clock, .reset, .sfrAddr, .sfrWrite,
    .sfrRead, .sfrWdata, .sfrRdata, .secAddr, .secWrite, .secRead,
    .secWdata, .secRdata, .iicEnable, .ledComOut, .ledComOe, .paIn, .pbIn,
    .pcIn, .pdIn, .paPad, .pbPad, .pcPad, .pdPad, .paPullup, .pbPullup,
    .pcPullup, .pdPullup, .pbPulldown, .pbHighSink, .sinkPortLock);

  always #25 clock = ~clock;

  // -------------------------------------------------------------------
  // bus tasks and comparison
  // -------------------------------------------------------------------
  // both buses see the address; only the chosen strobe is raised.
  // each call ends one cycle after the strobe so pads have settled
  task automatic access(input bit sec, wrt, input logic [7:0] a, d);
    @(negedge clock);
    sfrAddr = a;
    secAddr = a;
    sfrWdata = d;
    secWdata = d;
    sfrWrite = wrt && !sec;
    secWrite = wrt && sec;
    sfrRead = !wrt && !sec;
    secRead = !wrt && sec;
    @(negedge clock);
    {sfrWrite, secWrite, sfrRead, secRead} = 4'h0;
    @(negedge clock);
    got = sec ? secRdata : sfrRdata;
  endtask : access

  task automatic chk(input logic [7:0] g, e);
    compares++;
    if (g !== e) begin
      badCount++;
      $display("[FAIL] %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic rchk(input bit sec, input logic [7:0] a, e);
    access(sec, 1'b0, a, 8'h00);
    chk(got, e);
  endtask : rchk

  task automatic resetCheck();
    // pad synchronisers clear in reset and need two edges to refill
    repeat (2) @(negedge clock);
    for (int i = 0; i < 14; i++) begin
      rchk(0, OFFS[i], RSTS[i]);
    end
    rchk(1, 8'h2B, 8'h00);
    rchk(1, 8'h2C, 8'h00);
    chk(pbPad.oe, 8'h00);
  endtask : resetCheck

  task automatic conclude();
    $display("mismatches %0d, comparisons %0d", badCount, compares);
    if (badCount == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : conclude

  // a run needs well under a thousand cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      badCount++;
      conclude();
    end
  end

  // -------------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------------
  initial begin
    {clock, sfrWrite, sfrRead, secWrite, secRead, iicEnable} = 6'h00;
    {sfrAddr, sfrWdata, secAddr, secWdata} = 32'h0;
    // released pads sit high on outside pull-ups
    {paIn, pbIn, pcIn, pdIn} = 32'hFFFF_FFFF;
    ledComOut = 8'hA0;
    ledComOe = 8'hC0;
    reset = 1'b1;
    repeat (10) @(negedge clock);
    reset = 1'b0;
    resetCheck();
    rchk(0, 8'h00, 8'h00);
    // configuration registers keep only their implemented bits
    for (int i = 4; i < 14; i++) begin
      access(0, 1, OFFS[i], 8'hFF);
      rchk(0, OFFS[i], MASKS[i]);
    end
    chk(paPullup, 8'h3F);
    chk(pbPullup, 8'hFF);
    chk(pcPullup, 8'hFF);
    chk(pbPulldown, 8'hFF);
    chk(pbHighSink, 8'hFF);
    for (int i = 4; i < 10; i++) access(0, 1, OFFS[i], 8'h00);
    chk(pdPullup, 8'h00);
    chk(pbHighSink, 8'h00);
    access(1, 1, 8'h2C, 8'hFF);
    rchk(1, 8'h2C, 8'h07);
    access(0, 1, 8'h2C, 8'h00);
    rchk(1, 8'h2C, 8'h07);
    rchk(0, 8'h2C, 8'h00);
    rchk(1, 8'hEB, 8'h00);
    // push-pull output and mixed direction readback
    access(0, 1, 8'hEC, 8'h00);
    access(0, 1, 8'h90, 8'hA5);
    chk(pcPad.out, 8'hA5);
    chk(pcPad.oe, 8'hFF);
    rchk(0, 8'h90, 8'hA5);
    pdIn = 8'h3C;
    access(0, 1, 8'h98, 8'h55);
    access(0, 1, 8'hED, 8'hF0);
    chk(pdPad.oe, 8'h0F);
    rchk(0, 8'h98, 8'h35);
    // open drain on PA0, PA1 and PD6
    access(0, 1, 8'hED, 8'h00);
    access(0, 1, 8'h98, 8'h40);
    chk(pdPad.out, 8'h00);
    chk(pdPad.oe, 8'hBF);
    access(0, 1, 8'hEA, 8'h00);
    access(0, 1, 8'hF8, 8'hC2);
    rchk(0, 8'hF8, 8'h02);
    chk(paPad.out, 8'h00);
    chk(paPad.oe, 8'h3D);
    access(1, 1, 8'h2C, 8'h00);
    chk(paPad.out, 8'h02);
    chk(pdPad.oe, 8'hFF);
    // IIC enable forces open drain on PA0 and PA1 only; PD6 stays push-pull
    iicEnable = 1'b1;
    repeat (3) @(negedge clock);
    chk(paPad.out, 8'h00);
    chk(paPad.oe, 8'h3D);
    chk(pdPad.out, 8'h40);
    iicEnable = 1'b0;
    // common lines against the sink lock, scan fields set as well
    access(0, 1, 8'hEB, 8'h00);
    access(0, 1, 8'h80, 8'h0F);
    access(1, 1, 8'h2B, 8'hF0);
    chk(pbPad.out, 8'hAF);
    chk(pbPad.oe, 8'hCF);
    access(0, 1, 8'hB0, 8'h1F);
    chk({7'h00, sinkPortLock}, 8'h01);
    chk(pbPad.out, 8'h0F);
    chk(pbPad.oe, 8'hFF);
    chk(pbHighSink, 8'hFF);
    // reset again in mid-run
    pdIn = 8'hFF;
    reset = 1'b1;
    repeat (2) @(negedge clock);
    reset = 1'b0;
    resetCheck();
    conclude();
  end
endmodule : tb_gpio_port_config

bind gpio_port_config gpio_port_config_chk i_gpio_port_config_chk (
  .clock, .reset, .sfrAddr, .sfrWrite, .sfrRead, .sfrWdata, .sfrRdata,
  .secRead, .secRdata, .iicEnable, .paPad, .paPullup, .pbPulldown,
  .pbHighSink, .sinkPortLock);

`default_nettype wire
